// ---- logic/sebs_pkg.sv ----
// Package of constants and types for the servo enable and brake sequencer
// Summary of operation
// [R1] Servo ready rises only while initialisation is done and main power is present together.
// [R2] Protection becomes effective 1.5 s after initialisation starts.
// [R3] The host settles the travel inhibits and scale input before the start-up interval ends.
// [R4] Servo enable seen during the start-up interval is ignored until the interval has passed.
// [R5] On servo-off or alarm in motion the brake engages after the shorter of the moving delay and slowdown.
// [R6] An alarm at standstill engages the brake with zero delay.
// [R7] Servo-off at standstill engages the brake after the standstill delay setting.
// [R8] Servo-on is not accepted until measured speed is below the slow threshold.
// [R9] Servo enable re-asserted during deceleration waits until the motor has stopped.
// [R10] The brake release output low engages the brake and high opens it.
// [R11] The host stops the motor before toggling servo enable in normal operation.
// [R12] Energisation is removed and the motor free-runs before the brake delay counts.
// [R13] Speed is compared against a fixed threshold every control cycle.
package sebs_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int STARTUP_MS = 1500;
	localparam int STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
	localparam int SPEED_W = 16;
	localparam logic [SPEED_W-1:0] SLOW_RPM = 16'h001E;
	localparam int DELAY_W = 16;
	localparam int DELAY_UNIT_US = 1000;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * (CLK_HZ / 1000000);
	localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
	localparam logic [31:0] CNT_RST = 32'h00000000;

	typedef enum logic [2:0] {
		SEBS_ST_STARTUP = 3'b000,
		SEBS_ST_OFF = 3'b001,
		SEBS_ST_ON = 3'b010,
		SEBS_ST_BRAKE_WAIT = 3'b011,
		SEBS_ST_FREE_RUN = 3'b100
	} sebs_state_t;

	// Host facing control levels, all from pins
	typedef struct packed {
		logic servo_enable_in;
		logic alarm;
		logic init_done;
		logic main_power;
		logic cw_travel_inhibit;
		logic ccw_travel_inhibit;
	} sebs_ctl_t;

	// Delay settings in millisecond units
	typedef struct packed {
		logic [DELAY_W-1:0] standstill_brake_delay;
		logic [DELAY_W-1:0] moving_brake_delay;
	} sebs_cfg_t;
endpackage : sebs_pkg

// ---- logic/sebs_seq.sv ----
// Servo enable and holding brake sequencer
`timescale 1ns/1ns
module sebs_seq #(
	parameter int STARTUP_CYCLES = sebs_pkg::STARTUP_CYC,
	parameter int DELAY_UNIT_CYCLES = sebs_pkg::DELAY_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire sebs_pkg::sebs_ctl_t ctl_i,
	input wire sebs_pkg::sebs_cfg_t cfg_i,
	input wire logic [sebs_pkg::SPEED_W-1:0] speed_i,
	output logic servo_ready_o,
	output logic protect_active_o,
	output logic energise_o,
	output logic brake_release_out_o,
	output logic travel_fault_o
);
	import sebs_pkg::*;

	sebs_ctl_t ctl_s1_reg, ctl_s2_reg;
	sebs_state_t state_reg, state_next;
	logic [31:0] start_cnt_reg;
	logic [31:0] unit_cnt_reg;
	logic [DELAY_W-1:0] ms_cnt_reg;
	logic [DELAY_W-1:0] limit_reg;
	logic ready_reg, protect_reg, energise_reg, brake_reg, fault_reg;

	// Pins pass two flops before any logic reads them
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctl_s1_reg <= '0;
			ctl_s2_reg <= '0;
		end else if (ce_i) begin
			ctl_s1_reg <= ctl_i;
			ctl_s2_reg <= ctl_s1_reg;
		end
	end

	// Speed comes from on-chip logic and is compared each cycle
	wire slow_w = (speed_i < SLOW_RPM); // [R13]
	wire startup_over_w = (start_cnt_reg >= 32'(STARTUP_CYCLES)); // [R2]
	wire ready_w = ctl_s2_reg.init_done & ctl_s2_reg.main_power; // [R1]
	wire stop_req_w = ~ctl_s2_reg.servo_enable_in | ctl_s2_reg.alarm;
	wire delay_done_w = (ms_cnt_reg >= limit_reg);
	wire unit_tick_w = (unit_cnt_reg >= 32'(DELAY_UNIT_CYCLES - 1));
	wire on_ok_w = ready_w & ctl_s2_reg.servo_enable_in & ~ctl_s2_reg.alarm & slow_w; // [R8]

	// Sequence transitions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SEBS_ST_STARTUP: begin
				if (startup_over_w)
					state_next = SEBS_ST_OFF; // [R4]
			end
			SEBS_ST_OFF: begin
				if (on_ok_w)
					state_next = SEBS_ST_ON; // [R8] [R9]
			end
			SEBS_ST_ON: begin
				if (stop_req_w | ~ready_w) begin
					if (slow_w && ctl_s2_reg.alarm)
						state_next = SEBS_ST_OFF; // [R6]
					else if (slow_w)
						state_next = SEBS_ST_BRAKE_WAIT; // [R7]
					else
						state_next = SEBS_ST_FREE_RUN; // [R5]
				end
			end
			SEBS_ST_BRAKE_WAIT: begin
				if (delay_done_w)
					state_next = SEBS_ST_OFF;
			end
			SEBS_ST_FREE_RUN: begin
				if (delay_done_w | slow_w)
					state_next = SEBS_ST_OFF; // [R5]
			end
			default: state_next = SEBS_ST_STARTUP;
		endcase
	end

	// Start-up timer counts from release of reset, saturates
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			start_cnt_reg <= CNT_RST;
		end else if (ce_i && !startup_over_w) begin
			start_cnt_reg <= start_cnt_reg + 32'h00000001;
		end
	end

	// Delay counter restarts on entry to a brake wait, after energy is cut
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			unit_cnt_reg <= CNT_RST;
			ms_cnt_reg <= DELAY_RST;
			limit_reg <= DELAY_RST;
		end else if (ce_i) begin
			if (state_reg == SEBS_ST_ON) begin
				unit_cnt_reg <= CNT_RST;
				ms_cnt_reg <= DELAY_RST;
				limit_reg <= slow_w ? cfg_i.standstill_brake_delay : cfg_i.moving_brake_delay; // [R12]
			end else if (unit_tick_w) begin
				unit_cnt_reg <= CNT_RST;
				if (!delay_done_w)
					ms_cnt_reg <= ms_cnt_reg + 16'h0001;
			end else begin
				unit_cnt_reg <= unit_cnt_reg + 32'h00000001;
			end
		end
	end

	// State and registered outputs
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg <= SEBS_ST_STARTUP;
			ready_reg <= 1'b0;
			protect_reg <= 1'b0;
			energise_reg <= 1'b0;
			brake_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			ready_reg <= ready_w; // [R1]
			protect_reg <= startup_over_w; // [R2]
			// Energy drops the moment the sequence leaves ON
			energise_reg <= (state_next == SEBS_ST_ON); // [R12]
			// Brake stays open while energised or during a delay
			brake_reg <= (state_next == SEBS_ST_ON) || (state_next == SEBS_ST_BRAKE_WAIT) ||
				(state_next == SEBS_ST_FREE_RUN); // [R10]
			// Travel inhibits only count once protection is live
			fault_reg <= startup_over_w & (ctl_s2_reg.cw_travel_inhibit | ctl_s2_reg.ccw_travel_inhibit); // [R3]
		end
	end

	assign servo_ready_o = ready_reg;
	assign protect_active_o = protect_reg;
	assign energise_o = energise_reg;
	assign brake_release_out_o = brake_reg;
	assign travel_fault_o = fault_reg;
endmodule : sebs_seq

// ---- sim/sebs_seq_properties.sv ----
// Checker of sequencer timing at the block ports
`timescale 1ns/1ns
module sebs_seq_properties (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire sebs_pkg::sebs_ctl_t ctl_i,
	input wire sebs_pkg::sebs_cfg_t cfg_i,
	input wire logic [sebs_pkg::SPEED_W-1:0] speed_i,
	input wire logic servo_ready_o,
	input wire logic protect_active_o,
	input wire logic energise_o,
	input wire logic brake_release_out_o,
	input wire logic travel_fault_o
);
	import sebs_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Pins reach the outputs three edges later
	ready_both_a: assert property (servo_ready_o |->
		$past(ctl_i.init_done, 3) && $past(ctl_i.main_power, 3)) else $error("ready early");
	on_after_start_a: assert property (energise_o |-> protect_active_o) else $error("on in startup");
	on_when_slow_a: assert property ($rose(energise_o) |->
		$past(speed_i) < SLOW_RPM || $past(speed_i, 2) < SLOW_RPM) else $error("on while fast");
	// Brake may only close once energisation is gone
	free_first_a: assert property ($fell(brake_release_out_o) |-> !energise_o) else $error("brake on power");
	open_when_on_a: assert property (energise_o && $past(energise_o) |-> brake_release_out_o) else $error("shut");
	// Pin alarm reaches the state decision three edges before energise falls
	alarm_still_a: assert property ($fell(energise_o) && $past(ctl_i.alarm, 3) && speed_i < SLOW_RPM
		|-> ##[0:3] !brake_release_out_o) else $error("alarm delay");
	still_delay_a: assert property ($fell(energise_o) && !$past(ctl_i.alarm, 3) && speed_i < SLOW_RPM
		&& cfg_i.standstill_brake_delay != 16'h0000 |-> brake_release_out_o [*4]) else $error("no delay");
	fault_armed_a: assert property (travel_fault_o |-> protect_active_o) else $error("fault early");
endmodule : sebs_seq_properties
bind sebs_seq sebs_seq_properties sebs_seq_properties_inst (.clk_i, .rst_b_i, .ctl_i, .cfg_i, .speed_i,
	.servo_ready_o, .protect_active_o, .energise_o, .brake_release_out_o, .travel_fault_o);

// ---- sim/sebs_host.sv ----
// Host and coasting motor model
`timescale 1ns/1ns
module sebs_host (
	input wire logic clk_i,
	input wire logic energise_i,
	input wire logic load_i,
	input wire logic [15:0] spin_i,
	input wire sebs_pkg::sebs_ctl_t cmd_i,
	output sebs_pkg::sebs_ctl_t ctl_o,
	output logic [15:0] speed_o
);
	import sebs_pkg::*;
	assign ctl_o = cmd_i;
	// Unpowered motor loses one step a cycle
	always @(posedge clk_i) begin
		if (load_i) begin
			speed_o <= spin_i;
		end else if (!energise_i && speed_o != 16'h0000) begin
			speed_o <= speed_o - 16'h0001;
		end
	end
endmodule : sebs_host

// ---- sim/sebs_seq_tb.sv ----
// Testbench of the sequencer
`timescale 1ns/1ns
module sebs_seq_tb;
	import sebs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic ld = 1'b1;
	logic [15:0] spin = 16'h0000;
	sebs_ctl_t cmd = 6'h2C;
	sebs_ctl_t ctl;
	logic [15:0] spd;
	logic rdy, prot, en, brk, flt;
	int mismatches = 0;
	int tests_run = 0;
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	sebs_host sebs_host_inst (.clk_i, .energise_i(en), .load_i(ld), .spin_i(spin), .cmd_i(cmd), .ctl_o(ctl),
		.speed_o(spd));
	sebs_seq #(.STARTUP_CYCLES(100), .DELAY_UNIT_CYCLES(4)) sebs_seq_inst (.clk_i, .rst_b_i, .ce_i(1'b1),
		.ctl_i(ctl), .cfg_i(32'h00020003), .speed_i(spd), .servo_ready_o(rdy), .protect_active_o(prot),
		.energise_o(en), .brake_release_out_o(brk), .travel_fault_o(flt));
	task w(input int n);
		repeat (n) @(negedge clk_i);
	endtask : w
	task chk(input logic a, input logic e);
		tests_run++;
		if (a !== e) begin
			mismatches++;
			$display("BAD %0t wrong level", $time);
		end
	endtask : chk
	task final_report;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// Run needs about 460 cycles, so three times that is a hang
	initial begin
		repeat (1500) @(posedge clk_i);
		mismatches++;
		final_report();
	end
	initial begin
		w(2);
		rst_b_i = 1'b1;
		ld = 1'b0;
		w(20);
		chk(en, 1'b0);
		chk(rdy, 1'b1);
		w(90);
		chk(prot, 1'b1);
		chk(brk, 1'b1);
		cmd.servo_enable_in = 1'b0;
		w(6);
		chk(brk, 1'b1);
		w(14);
		chk(brk, 1'b0);
		// Enable again while the motor coasts
		spin = 16'h0064;
		ld = 1'b1;
		cmd.servo_enable_in = 1'b1;
		w(1);
		ld = 1'b0;
		w(9);
		chk(en, 1'b0);
		w(80);
		chk(en, 1'b1);
		spin = 16'h00C8;
		ld = 1'b1;
		w(1);
		ld = 1'b0;
		cmd.alarm = 1'b1;
		w(6);
		chk(en, 1'b0);
		chk(brk, 1'b1);
		w(20);
		chk(brk, 1'b0);
		cmd.alarm = 1'b0;
		w(200);
		chk(en, 1'b1);
		cmd.alarm = 1'b1;
		w(6);
		chk(brk, 1'b0);
		cmd.cw_travel_inhibit = 1'b1;
		cmd.main_power = 1'b0;
		w(5);
		chk(flt, 1'b1);
		chk(rdy, 1'b0);
		final_report();
	end
endmodule : sebs_seq_tb
